// *** rtcc_bcd_step.sv ***
// One BCD counter step: next value and wrap out of the last value.
// Assumes a valid BCD value at the input.
`timescale 1ns/10ps
`default_nettype none
module rtcc_bcd_step (
    input wire logic [7:0] in_i,
    input wire logic [7:0] last_i,
    input wire logic [7:0] first_i,
    output logic [7:0] next_o,
    output logic wrap_o
);
    // Wrap at last, carry units into tens at nine
    always_comb begin
        wrap_o = (in_i == last_i);
        if (wrap_o) begin
            next_o = first_i;
        end else if (in_i[3:0] >= 4'h9) begin
            next_o = {in_i[7:4] + 4'h1, 4'h0};
        end else begin
            next_o = {in_i[7:4], in_i[3:0] + 4'h1};
        end
    end
endmodule // rtcc_bcd_step
`default_nettype wire

// *** rtcc_core.sv ***
// Control, status and time counter registers of the real-time clock.
// Assumes an external serial-bus slave that marks transaction start and
// stop, loads the pointer and strobes byte reads and writes.
`timescale 1ns/10ps
`default_nettype none
module rtcc_core import rtcc_pkg::*; #(
    parameter int OSC_DIV = OSC_DIV_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_stopped_i,
    input wire logic osc_tick_i,
    input wire logic bus_start_i,
    input wire logic bus_stop_i,
    input wire logic ptr_load_i,
    input wire logic [3:0] ptr_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_i,
    input wire logic alarm_event_i,
    input wire logic timer_event_i,
    input wire logic timer_pulse_i,
    input wire logic supply_low_i,
    output logic [7:0] rdata_o,
    output logic int_out_o,
    output logic int_oe_o,
    output logic por_override_o
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic int_rst; // Internal reset
    logic external_clock_test_select; // Test clock mode, stored only
    logic stop; // Timekeeping halted
    logic por_override_enable; // Override facility armed
    logic interrupt_pulse_select; // Pulse mode for timer interrupt
    logic alarm_flag;
    logic timer_flag;
    logic alarm_irq_enable;
    logic timer_irq_enable;
    logic voltage_low_flag;
    logic [6:0] sec; // BCD seconds
    logic [6:0] minute; // BCD minutes
    logic [5:0] hour; // BCD hours
    logic [5:0] day; // BCD day of month
    logic [2:0] wday; // Weekday
    logic century;
    logic [4:0] month; // BCD month
    logic [7:0] year; // BCD year
    logic [7:0] aux [0:6]; // Alarm, clock-out and timer storage
    logic [3:0] ptr; // Register address pointer
    logic busy; // Bus transaction open
    logic pending; // Second missed during access
    logic step; // Advance the time this cycle
    logic irq; // Interrupt request level
    logic leap; // Year divisible by four
    logic [7:0] day_last; // Last day of current month
    logic [7:0] sec_n, min_n, hour_n, day_n, wday_n, mon_n, year_n;
    logic sec_w, min_w, hour_w, day_w, wday_w, mon_w, year_w;
    logic [7:0] rsel; // Read mux

    rtcc_tick_if tk ();

    assign int_rst = rst_i | osc_stopped_i;

    // -----------------------------------------------------------------
    // Divider to one-second tick
    // -----------------------------------------------------------------
    assign tk.osc_tick = osc_tick_i;
    assign tk.halt = stop | int_rst;
    rtcc_prescaler #(.DIV(OSC_DIV)) u_div (
        .clk_i(clk_i),
        .rst_i(int_rst),
        .tk(tk)
    );

    // -----------------------------------------------------------------
    // Control one
    // -----------------------------------------------------------------
    // Reserved bits are not stored; host keeps them zero
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            external_clock_test_select <= RST_CTRL_ONE[BIT_EXTERNAL_TEST_CLOCK_TEST];
            stop <= RST_CTRL_ONE[BIT_STOP];
            por_override_enable <= RST_CTRL_ONE[BIT_POR_OVR];
        end else if (wr_i && ptr == OFS_CTRL_ONE) begin
            external_clock_test_select <= wdata_i[BIT_EXTERNAL_TEST_CLOCK_TEST];
            stop <= wdata_i[BIT_STOP];
            por_override_enable <= wdata_i[BIT_POR_OVR];
        end
    end

    // -----------------------------------------------------------------
    // Control two: enables and pulse select
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            interrupt_pulse_select <= 1'b0;
            alarm_irq_enable <= 1'b0;
            timer_irq_enable <= 1'b0;
        end else if (wr_i && ptr == OFS_CTRL_TWO) begin
            interrupt_pulse_select <= wdata_i[BIT_PULSE_SEL];
            alarm_irq_enable <= wdata_i[BIT_ALARM_IE];
            timer_irq_enable <= wdata_i[BIT_TIMER_IE];
        end
    end

    // Flags: event sets, written zero clears, set wins
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            alarm_flag <= 1'b0;
            timer_flag <= 1'b0;
        end else begin
            if (alarm_event_i) begin
                alarm_flag <= 1'b1;
            end else if (wr_i && ptr == OFS_CTRL_TWO && !wdata_i[BIT_ALARM_FLAG]) begin
                alarm_flag <= 1'b0;
            end
            if (timer_event_i) begin
                timer_flag <= 1'b1;
            end else if (wr_i && ptr == OFS_CTRL_TWO && !wdata_i[BIT_TIMER_FLAG]) begin
                timer_flag <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Interrupt pin, open drain: drive low when requested
    // -----------------------------------------------------------------
    always_comb begin
        irq = alarm_flag && alarm_irq_enable;
        if (timer_irq_enable) begin
            if (interrupt_pulse_select) begin
                irq = irq || timer_pulse_i;
            end else begin
                irq = irq || timer_flag;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            int_oe_o <= 1'b0;
            int_out_o <= 1'b0;
            por_override_o <= RST_CTRL_ONE[BIT_POR_OVR];
        end else begin
            int_oe_o <= irq;
            int_out_o <= 1'b0;
            por_override_o <= por_override_enable;
        end
    end

    // -----------------------------------------------------------------
    // Bus access: pointer, freeze and missed second
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            ptr <= 4'h0;
        end else if (ptr_load_i) begin
            ptr <= ptr_i;
        end else if (wr_i || rd_i) begin
            ptr <= ptr + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            busy <= 1'b0;
        end else if (bus_start_i) begin
            busy <= 1'b1;
        end else if (bus_stop_i) begin
            busy <= 1'b0;
        end
    end

    // Remember a tick while frozen; a tick on the catch-up cycle stays
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            pending <= 1'b0;
        end else if (busy) begin
            pending <= pending | tk.sec_tick;
        end else begin
            pending <= pending & tk.sec_tick;
        end
    end

    assign step = (tk.sec_tick | pending) & ~busy & ~stop;

    // -----------------------------------------------------------------
    // Calendar chain
    // -----------------------------------------------------------------
    assign leap = ~year[0] & ~(year[1] ^ year[4]);

    always_comb begin
        if (month == 5'h02) begin
            day_last = leap ? 8'h29 : 8'h28;
        end else if (month == 5'h04 || month == 5'h06 || month == 5'h09 || month == 5'h11) begin
            day_last = 8'h30;
        end else begin
            day_last = 8'h31;
        end
    end

    rtcc_bcd_step u_sec (.in_i({1'b0, sec}), .last_i(BCD_59), .first_i(BCD_00),
        .next_o(sec_n), .wrap_o(sec_w));
    rtcc_bcd_step u_min (.in_i({1'b0, minute}), .last_i(BCD_59), .first_i(BCD_00),
        .next_o(min_n), .wrap_o(min_w));
    rtcc_bcd_step u_hour (.in_i({2'b00, hour}), .last_i(BCD_23), .first_i(BCD_00),
        .next_o(hour_n), .wrap_o(hour_w));
    rtcc_bcd_step u_day (.in_i({2'b00, day}), .last_i(day_last), .first_i(BCD_01),
        .next_o(day_n), .wrap_o(day_w));
    rtcc_bcd_step u_wday (.in_i({5'b00000, wday}), .last_i(BCD_06), .first_i(BCD_00),
        .next_o(wday_n), .wrap_o(wday_w));
    rtcc_bcd_step u_mon (.in_i({3'b000, month}), .last_i(BCD_12), .first_i(BCD_01),
        .next_o(mon_n), .wrap_o(mon_w));
    rtcc_bcd_step u_year (.in_i(year), .last_i(BCD_99), .first_i(BCD_00),
        .next_o(year_n), .wrap_o(year_w));

    // Time fields carry no reset; host writes win over the tick
    always_ff @(posedge clk_i) begin
        if (wr_i && !int_rst) begin
            unique case (ptr)
                OFS_SECONDS: sec <= wdata_i[6:0];
                OFS_MINUTES: minute <= wdata_i[6:0];
                OFS_HOURS: hour <= wdata_i[5:0];
                OFS_DAYS: day <= wdata_i[5:0];
                OFS_WEEKDAY: wday <= wdata_i[2:0];
                OFS_MONTH: begin
                    century <= wdata_i[BIT_CENTURY];
                    month <= wdata_i[4:0];
                end
                OFS_YEAR: year <= wdata_i;
                default: ;
            endcase
        end else if (step) begin
            sec <= sec_n[6:0];
            if (sec_w) begin
                minute <= min_n[6:0];
            end
            if (sec_w && min_w) begin
                hour <= hour_n[5:0];
            end
            if (sec_w && min_w && hour_w) begin
                day <= day_n[5:0];
                wday <= wday_n[2:0];
            end
            if (sec_w && min_w && hour_w && day_w) begin
                month <= mon_n[4:0];
            end
            if (sec_w && min_w && hour_w && day_w && mon_w) begin
                year <= year_n;
                century <= century ^ year_w;
            end
        end
    end

    // Voltage-low flag: set at start-up and on low supply, set wins
    always_ff @(posedge clk_i) begin
        if (int_rst || supply_low_i) begin
            voltage_low_flag <= 1'b1;
        end else if (wr_i && ptr == OFS_SECONDS) begin
            voltage_low_flag <= wdata_i[BIT_VLOW];
        end
    end

    // -----------------------------------------------------------------
    // Alarm, clock-out and timer storage: only defined bits reset
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            for (int i = 0; i < 4; i++) begin
                aux[i][7] <= RST_AUX_HI[7];
            end
            aux[4][7] <= RST_CLOCK_OUTPUT[7];
            aux[4][1:0] <= RST_CLOCK_OUTPUT[1:0];
            aux[5][7] <= RST_TIMER_CTL[7];
            aux[5][1:0] <= RST_TIMER_CTL[1:0];
        end else if (wr_i && ptr >= OFS_AUX_FIRST) begin
            aux[3'(ptr - OFS_AUX_FIRST)] <= wdata_i;
        end
    end

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    always_comb begin
        unique case (ptr)
            OFS_CTRL_ONE: rsel = {external_clock_test_select, 1'b0, stop, 1'b0,
                por_override_enable, 3'b000};
            OFS_CTRL_TWO: rsel = {3'b000, interrupt_pulse_select, alarm_flag,
                timer_flag, alarm_irq_enable, timer_irq_enable};
            OFS_SECONDS: rsel = {voltage_low_flag, sec};
            OFS_MINUTES: rsel = {1'b0, minute};
            OFS_HOURS: rsel = {2'b00, hour};
            OFS_DAYS: rsel = {2'b00, day};
            OFS_WEEKDAY: rsel = {5'b00000, wday};
            OFS_MONTH: rsel = {century, 2'b00, month};
            OFS_YEAR: rsel = year;
            default: rsel = aux[3'(ptr - OFS_AUX_FIRST)];
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rsel;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_tick_frozen;
        busy && tk.sec_tick && !int_rst;
    endsequence

    // Access over, a second owed, nothing blocking it
    sequence s_catch_up;
        !busy && pending && !stop && !wr_i;
    endsequence

    chk_stop_halts: assert property (@(posedge clk_i) disable iff (int_rst)
        stop && !wr_i |=> $stable(sec))
        else $error("seconds moved while stopped");
    chk_ptr_home: assert property (@(posedge clk_i)
        int_rst |=> ptr == 4'h0 && !busy)
        else $error("pointer not home after reset");
    chk_ctrl_reset: assert property (@(posedge clk_i)
        int_rst |=> rsel == RST_CTRL_ONE && voltage_low_flag && !alarm_flag)
        else $error("reset values wrong");
    chk_alarm_hold: assert property (@(posedge clk_i) disable iff (int_rst)
        alarm_flag && alarm_irq_enable |=> int_oe_o)
        else $error("alarm interrupt not active");
    chk_level_mode: assert property (@(posedge clk_i) disable iff (int_rst)
        !interrupt_pulse_select && timer_irq_enable && timer_flag |=> int_oe_o)
        else $error("timer level interrupt missing");
    chk_no_cause: assert property (@(posedge clk_i) disable iff (int_rst)
        !irq |=> !int_oe_o)
        else $error("interrupt without cause");
    chk_freeze_time: assert property (@(posedge clk_i) disable iff (int_rst)
        busy && !wr_i |=> $stable(sec) && $stable(year))
        else $error("time moved during access");
    chk_missed_sec: assert property (@(posedge clk_i) disable iff (int_rst)
        s_tick_frozen |=> pending)
        else $error("missed second lost");
    chk_catch_up: assert property (@(posedge clk_i) disable iff (int_rst)
        s_catch_up |=> sec != $past(sec))
        else $error("missed second not applied");
    chk_leap_day: assert property (@(posedge clk_i) disable iff (int_rst)
        step && !wr_i && month == 5'h02 && day == 6'h28 && leap && sec_w && min_w && hour_w
        |=> day == 6'h29)
        else $error("leap day skipped");
    chk_century: assert property (@(posedge clk_i) disable iff (int_rst)
        step && !wr_i && sec_w && min_w && hour_w && day_w && mon_w && year_w
        |=> century != $past(century) && year == 8'h00)
        else $error("century not toggled");
endmodule // rtcc_core
`default_nettype wire

// *** rtcc_host_model.sv ***
// Host model: serial-bus host as seen at the core's register port.
// Assumes a shared clock; bench calls its tasks hierarchically.
`timescale 1ns/10ps
`default_nettype none
module rtcc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic bus_start_o,
    output logic bus_stop_o,
    output logic ptr_load_o,
    output logic [3:0] ptr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o
);
    logic [7:0] buf_q [0:7]; // Bytes to send or bytes received
    // ----------------------------------------
    // Idle levels and transaction framing
    // ----------------------------------------
    initial {bus_start_o, bus_stop_o, ptr_load_o, wr_o, rd_o, ptr_o, wdata_o} = '0;
    task automatic frame(input logic stop);
        @(posedge clk_i);
        if (stop) bus_stop_o <= 1'b1;
        else bus_start_o <= 1'b1;
        @(posedge clk_i);
        {bus_start_o, bus_stop_o} <= 2'b00;
    endtask
    // Optional pointer load, then n single-cycle byte strobes
    task automatic access(input logic [3:0] p, input int n, input logic is_rd, input logic load);
        logic [3:0] q;
        if (load) begin
            @(posedge clk_i);
            ptr_load_o <= 1'b1;
            ptr_o <= p;
            @(posedge clk_i);
            ptr_load_o <= 1'b0;
        end
        for (int i = 0; i < n; i++) begin
            q = p + i[3:0];
            @(posedge clk_i);
            wdata_o <= buf_q[i] & ((q == 4'h0) ? 8'ha8 : (q == 4'h1) ? 8'h1f : 8'hff);
            if (is_rd) rd_o <= 1'b1;
            else wr_o <= 1'b1;
            @(posedge clk_i);
            {rd_o, wr_o} <= 2'b00;
            #1 if (is_rd) buf_q[i] = rdata_i;
        end
    endtask
    // Whole access inside one transaction
    task automatic xfer(input logic [3:0] p, input int n, input logic is_rd, input logic load);
        frame(1'b0);
        access(p, n, is_rd, load);
        frame(1'b1);
    endtask
endmodule // rtcc_host_model
`default_nettype wire

// *** rtcc_pkg.sv ***
// Package: register map, field positions, reset values and timing counts
// for the real-time clock control and time counters.
// Assumes nothing of its surroundings; imported by rtcc_core, rtcc_prescaler and the testbench.
package rtcc_pkg;
    // -----------------------------------------------------------------
    // Register offsets
    // -----------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
    localparam logic [3:0] OFS_SECONDS = 4'h2;
    localparam logic [3:0] OFS_MINUTES = 4'h3;
    localparam logic [3:0] OFS_HOURS = 4'h4;
    localparam logic [3:0] OFS_DAYS = 4'h5;
    localparam logic [3:0] OFS_WEEKDAY = 4'h6;
    localparam logic [3:0] OFS_MONTH = 4'h7;
    localparam logic [3:0] OFS_YEAR = 4'h8;
    localparam logic [3:0] OFS_AUX_FIRST = 4'h9;
    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int BIT_EXTERNAL_TEST_CLOCK_TEST = 7;
    localparam int BIT_STOP = 5;
    localparam int BIT_POR_OVR = 3;
    localparam int BIT_PULSE_SEL = 4;
    localparam int BIT_ALARM_FLAG = 3;
    localparam int BIT_TIMER_FLAG = 2;
    localparam int BIT_ALARM_IE = 1;
    localparam int BIT_TIMER_IE = 0;
    localparam int BIT_VLOW = 7;
    localparam int BIT_CENTURY = 7;
    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_CTRL_ONE = 8'h08;
    localparam logic [7:0] RST_AUX_HI = 8'h80;
    localparam logic [7:0] RST_CLOCK_OUTPUT = 8'h80;
    localparam logic [7:0] RST_TIMER_CTL = 8'h03;
    // -----------------------------------------------------------------
    // Counter limits (BCD)
    // -----------------------------------------------------------------
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_06 = 8'h06;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_00 = 8'h00;
    // -----------------------------------------------------------------
    // Timing: oscillator rate in Hz gives ticks per second
    // -----------------------------------------------------------------
    localparam int OSC_HZ = 32768;
    localparam int SEC_HZ = 1;
    localparam int OSC_DIV_DEFAULT = OSC_HZ / SEC_HZ;
endpackage

// *** rtcc_prescaler.sv ***
// Divider from oscillator ticks to a one-second tick.
// Assumes osc_tick pulses are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module rtcc_prescaler import rtcc_pkg::*; #(
    parameter int DIV = OSC_DIV_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    rtcc_tick_if.div tk
);
    // -----------------------------------------------------------------
    // Divider chain
    // -----------------------------------------------------------------
    logic [$clog2(DIV)-1:0] cnt; // Ticks within the second
    localparam logic [$clog2(DIV)-1:0] CNT_LAST = ($clog2(DIV))'(DIV - 1);

    // Count ticks; halt clears the whole chain
    always_ff @(posedge clk_i) begin
        if (rst_i || tk.halt) begin
            cnt <= '0;
            tk.sec_tick <= 1'b0;
        end else begin
            tk.sec_tick <= tk.osc_tick && (cnt == CNT_LAST);
            if (tk.osc_tick) begin
                cnt <= (cnt == CNT_LAST) ? '0 : cnt + 1'b1;
            end
        end
    end

    chk_halt_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        tk.halt |=> (cnt == '0) && !tk.sec_tick)
        else $error("divider not cleared while halted");
endmodule // rtcc_prescaler
`default_nettype wire

// *** rtcc_tick_if.sv ***
// Interface: oscillator ticks in, 1 Hz tick out, stop clear.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface rtcc_tick_if;
    logic osc_tick; // One pulse per oscillator period
    logic halt; // Clears the divider chain
    logic sec_tick; // One pulse per second
    modport div (input osc_tick, input halt, output sec_tick);
    modport core (output osc_tick, output halt, input sec_tick);
endinterface
`default_nettype wire

// *** tb_rtcc_core.sv ***
// Testbench: reset, calendar, freeze, stop and interrupt scenarios.
// Assumes rtcc_pkg, rtcc_core and rtcc_host_model compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_rtcc_core import rtcc_pkg::*;;
    localparam int DIV = 4; // Short second
    localparam logic [55:0] CAL_IN [3] = '{56'h04_02_06_28_23_59_59,
        56'h01_02_03_28_23_59_59, 56'h99_12_05_31_23_59_59};
    localparam logic [55:0] CAL_OUT [3] = '{56'h04_02_00_29_00_00_00,
        56'h01_03_04_01_00_00_00, 56'h00_81_06_01_00_00_00};
    logic clk_i = 1'b0, rst_i = 1'b1, osc_stopped_i = 1'b0, osc_tick_i = 1'b0;
    logic alarm_event_i = 1'b0, timer_event_i = 1'b0, timer_pulse_i = 1'b0, supply_low_i = 1'b0;
    logic bus_start_i, bus_stop_i, ptr_load_i, wr_i, rd_i, int_out_o, int_oe_o, por_override_o;
    logic [3:0] ptr_i;
    logic [7:0] wdata_i, rdata_o;
    int err_count = 0, comparisons = 0;
    initial forever #5 clk_i = ~clk_i;
    rtcc_core #(.OSC_DIV(DIV)) uut (.clk_i, .rst_i, .osc_stopped_i, .osc_tick_i, .bus_start_i,
        .bus_stop_i, .ptr_load_i, .ptr_i, .wr_i, .wdata_i, .rd_i, .alarm_event_i, .timer_event_i,
        .timer_pulse_i, .supply_low_i, .rdata_o, .int_out_o, .int_oe_o, .por_override_o);
    rtcc_host_model h (.clk_i, .rdata_i(rdata_o), .bus_start_o(bus_start_i),
        .bus_stop_o(bus_stop_i), .ptr_load_o(ptr_load_i), .ptr_o(ptr_i), .wr_o(wr_i),
        .wdata_o(wdata_i), .rd_o(rd_i));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n); // n oscillator pulses, then settle
        repeat (n) begin
            @(posedge clk_i) osc_tick_i <= 1'b1;
            @(posedge clk_i) osc_tick_i <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
    endtask
    task automatic put(input logic [3:0] p, input logic [7:0] v);
        h.buf_q[0] = v;
        h.xfer(p, 1, 1'b0, 1'b1);
    endtask
    task automatic get(input logic [3:0] p, input logic [7:0] exp);
        h.xfer(p, 1, 1'b1, 1'b1);
        chk(h.buf_q[0], exp);
    endtask
    task automatic end_of_test();
        if (err_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_vals(); // Read from pointer left by reset
        h.xfer(4'h0, 3, 1'b1, 1'b0);
        chk(h.buf_q[0], RST_CTRL_ONE);
        chk(h.buf_q[1], 8'h00);
        chk(h.buf_q[2][7], 1'b1);
        chk(por_override_o, 1'b1);
    endtask
    task automatic t_calendar(); // Leap, non-leap and century rollover
        logic [55:0] got;
        for (int i = 0; i < 3; i++) begin
            for (int b = 0; b < 7; b++) h.buf_q[b] = CAL_IN[i][8*b+:8];
            h.xfer(OFS_SECONDS, 7, 1'b0, 1'b1);
            tick(DIV);
            h.xfer(OFS_SECONDS, 7, 1'b1, 1'b1);
            for (int b = 0; b < 7; b++) got[8*b+:8] = h.buf_q[b];
            chk(got, CAL_OUT[i]);
        end
    endtask
    task automatic t_freeze(); // Second during open transaction is held
        put(OFS_SECONDS, 8'h10);
        h.frame(1'b0);
        tick(DIV);
        h.access(OFS_SECONDS, 1, 1'b1, 1'b1);
        chk(h.buf_q[0], 8'h10);
        h.frame(1'b1);
        repeat (3) @(posedge clk_i);
        get(OFS_SECONDS, 8'h11);
    endtask
    task automatic t_stop(); // Stopped clock, voltage-low flag, override bit
        put(OFS_CTRL_ONE, 8'ha8);
        get(OFS_CTRL_ONE, 8'ha8);
        tick(2 * DIV);
        get(OFS_SECONDS, 8'h11);
        @(posedge clk_i) supply_low_i <= 1'b1;
        @(posedge clk_i) supply_low_i <= 1'b0;
        get(OFS_SECONDS, 8'h91);
        put(OFS_CTRL_ONE, 8'h00);
        chk(por_override_o, 1'b0);
    endtask
    task automatic t_osc_reset(); // Oscillator stop acts as reset
        put(OFS_CTRL_TWO, 8'h03);
        h.buf_q[0] = 8'h7f;
        h.buf_q[1] = 8'hfc;
        h.xfer(4'hd, 2, 1'b0, 1'b1);
        @(posedge clk_i) osc_stopped_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        osc_stopped_i <= 1'b0;
        h.xfer(4'h0, 3, 1'b1, 1'b0);
        chk(h.buf_q[0], RST_CTRL_ONE);
        chk(h.buf_q[1], 8'h00);
        chk(h.buf_q[2], 8'h91);
        chk(por_override_o, 1'b1);
        h.xfer(4'hd, 2, 1'b1, 1'b1);
        chk(h.buf_q[0], 8'hfc);
        chk(h.buf_q[1], 8'h7f);
    endtask
    task automatic t_irq(); // Alarm, level mode and pulse mode
        put(OFS_CTRL_TWO, 8'h02);
        @(posedge clk_i) alarm_event_i <= 1'b1;
        @(posedge clk_i) alarm_event_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(int_oe_o, 1'b1);
        get(OFS_CTRL_TWO, 8'h0a);
        put(OFS_CTRL_TWO, 8'h11);
        @(posedge clk_i) timer_event_i <= 1'b1;
        @(posedge clk_i) timer_event_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({int_oe_o, int_out_o}, 2'b00);
        @(posedge clk_i) timer_pulse_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(int_oe_o, 1'b1);
        timer_pulse_i <= 1'b0;
        put(OFS_CTRL_TWO, 8'h05);
        chk(int_oe_o, 1'b1);
        put(OFS_CTRL_TWO, 8'h01);
        chk(int_oe_o, 1'b0);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_vals();
        t_calendar();
        t_freeze();
        t_stop();
        t_osc_reset();
        t_irq();
        end_of_test();
    end
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
endmodule // tb_rtcc_core
`default_nettype wire
